//--- design/clock_wake_lvd_config.sv
// Clock divider, option byte capture, gain decode and start-up delay sequencer.
// Assumes option bytes are stable while reset_i is high and an APB master.

// Overview of operation
// - CPU clock divided by one-hot selector
// - Divider register read/write, resets zero
// - Two-bit option picks clock source
// - Gain field decoded to stage enables
// - Trim field drives oscillator current generators
// - Trim option resets to twenty
// - Detector field: off, medium, lowest, highest
// - Hold CPU 4096 times wake plus one
// - Internal source skips the prescaled delay
// - Initial 4096-cycle delay first after reset and slow causes
// - Detector or watchdog reset restarts immediately
// - Separate CPU and peripheral clock enables
module clock_wake_lvd_config #(
   parameter int unsigned INIT_CYCLES = clock_wake_lvd_pkg::INITIAL_DELAY_CYCLES,
   parameter int unsigned UNIT_CYCLES = clock_wake_lvd_pkg::PRESCALE_UNIT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Reset and wake causes
   input wire logic ext_reset_i,
   input wire logic por_reset_i,
   input wire logic halt_wake_i,
   input wire logic lvd_reset_i,
   input wire logic wdog_reset_i,
   // Option bytes
   input wire logic [7:0] opt_clock_source_i,
   input wire logic [7:0] opt_gain_i,
   input wire logic [7:0] opt_trim_i,
   input wire logic [7:0] opt_low_voltage_i,
   input wire logic [7:0] opt_wake_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Clock network controls
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic [1:0] clock_source_o,
   output logic [7:0] gain_stage_en_o,
   output logic gain_code_bad_o,
   output logic [5:0] trim_o,
   output logic [1:0] lv_level_o,
   output logic lv_enable_o,
   output logic osc_enable_o,
   output logic cpu_run_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Divide ratio minus one from the one-hot selector
   function automatic logic [5:0] div_limit(input logic [5:0] sel);
      unique case (sel)
         6'h00: div_limit = 6'h00;
         6'h01: div_limit = 6'h01;
         6'h02: div_limit = 6'h03;
         6'h04: div_limit = 6'h07;
         6'h08: div_limit = 6'h0f;
         6'h10: div_limit = 6'h1f;
         default: div_limit = 6'h3f; // 100000 and all others: /64
      endcase
   endfunction

   typedef enum logic [1:0]
   {
      ST_RESET = 2'b00,
      ST_INIT = 2'b01,
      ST_PRESCALE = 2'b10,
      ST_RUN = 2'b11
   } seq_state_t;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] cause_meta_reg; // First synchroniser stage of causes
   logic [7:0] cause_sync_reg; // Second stage, safe to read
   logic [5:0] cpu_div_reg; // Software divide selector
   logic [5:0] div_cnt_reg; // Divider counter
   logic [1:0] clock_source_reg; // Frozen clock source option
   logic [2:0] gain_reg; // Frozen gain option
   logic [5:0] trim_reg; // Frozen trim option
   logic [1:0] lv_reg; // Frozen detector option
   logic [7:0] wake_reg; // Frozen wake prescaler
   seq_state_t state_reg; // Start-up sequencer
   logic [12:0] cyc_cnt_reg; // Cycles within one unit
   logic [8:0] unit_cnt_reg; // Prescaler units elapsed
   logic ext_req; // Slow restart requested
   logic fast_req; // Immediate restart requested
   logic [5:0] div_lim;
   logic apb_access;
   logic [31:0] rdata;

   // Cause vector: ext, por, halt, lvd, wdog
   always_ff @(posedge clk_i)
   begin
      cause_meta_reg <= {3'h0, ext_reset_i, por_reset_i, halt_wake_i, lvd_reset_i, wdog_reset_i};
      cause_sync_reg <= cause_meta_reg;
   end

   assign ext_req = cause_sync_reg[4] | cause_sync_reg[3] | cause_sync_reg[2];
   assign fast_req = cause_sync_reg[1] | cause_sync_reg[0];

   // ----------------------------------------
   // Option byte capture
   // ----------------------------------------
   // Sampled only while reset is high
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         clock_source_reg <= opt_clock_source_i[1:0];
         gain_reg <= opt_gain_i[2:0];
         trim_reg <= opt_trim_i[5:0];
         lv_reg <= opt_low_voltage_i[1:0];
         wake_reg <= opt_wake_i;
      end
   end

   // Source decode: upper bit set means RC
   always_comb
   begin
      if (clock_source_reg[1])
         clock_source_o = clock_wake_lvd_pkg::SRC_RC;
      else
         clock_source_o = clock_source_reg;
   end

   // Gain stages as thermometer enables
   always_comb
   begin
      gain_code_bad_o = 1'b0;
      unique case (gain_reg)
         3'h0: gain_stage_en_o = 8'h00;
         3'h1: gain_stage_en_o = 8'h01;
         3'h3: gain_stage_en_o = 8'h07;
         3'h5: gain_stage_en_o = 8'h3f;
         3'h7: gain_stage_en_o = 8'hff;
         default:
         begin
            gain_stage_en_o = 8'h00; // Illegal codes enable nothing
            gain_code_bad_o = 1'b1;
         end
      endcase
   end

   assign trim_o = trim_reg; // relies on the programmer
   assign lv_level_o = lv_reg;
   assign lv_enable_o = (lv_reg != clock_wake_lvd_pkg::LV_OFF);

   // ----------------------------------------
   // CPU divider register
   // ----------------------------------------
   assign apb_access = psel_i & penable_i;

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         cpu_div_reg <= clock_wake_lvd_pkg::CPU_DIV_RESET;
      else if (apb_access & pwrite_i & (paddr_i == clock_wake_lvd_pkg::ADDR_CPU_DIV))
         cpu_div_reg <= pwdata_i[5:0];
   end

   assign div_lim = div_limit(cpu_div_reg);

   // Divider counter; CPU enable pulses once per period
   always_ff @(posedge clk_i)
   begin
      if (reset_i || div_cnt_reg >= div_lim)
         div_cnt_reg <= 6'h00;
      else
         div_cnt_reg <= div_cnt_reg + 6'h01;
   end

   assign cpu_clk_en_o = cpu_run_o & (div_cnt_reg == 6'h00);
   assign periph_clk_en_o = cpu_run_o;

   // ----------------------------------------
   // Start-up sequencer
   // ----------------------------------------
   // Init delay, optional prescaled delay, then run
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_reg <= ST_RESET;
         cyc_cnt_reg <= 13'h0000;
         unit_cnt_reg <= 9'h000;
      end
      else if (fast_req)
      begin
         state_reg <= ST_RUN;
         cyc_cnt_reg <= 13'h0000;
         unit_cnt_reg <= 9'h000;
      end
      else if (ext_req)
      begin
         state_reg <= ST_INIT;
         cyc_cnt_reg <= 13'h0000;
         unit_cnt_reg <= 9'h000;
      end
      else
      begin
         unique case (state_reg)
            ST_RESET:
            begin
               state_reg <= ST_INIT;
            end
            ST_INIT:
            begin
               if (cyc_cnt_reg == 13'(INIT_CYCLES - 1))
               begin
                  cyc_cnt_reg <= 13'h0000;
                  if (clock_source_o == clock_wake_lvd_pkg::SRC_INTERNAL)
                     state_reg <= ST_RUN;
                  else
                     state_reg <= ST_PRESCALE;
               end
               else
                  cyc_cnt_reg <= cyc_cnt_reg + 13'h0001;
            end
            ST_PRESCALE:
            begin
               if (cyc_cnt_reg == 13'(UNIT_CYCLES - 1))
               begin
                  cyc_cnt_reg <= 13'h0000;
                  if (unit_cnt_reg == {1'b0, wake_reg})
                     state_reg <= ST_RUN;
                  else
                     unit_cnt_reg <= unit_cnt_reg + 9'h001;
               end
               else
                  cyc_cnt_reg <= cyc_cnt_reg + 13'h0001;
            end
            ST_RUN:
            begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   assign cpu_run_o = (state_reg == ST_RUN);
   assign osc_enable_o = 1'b1; // Oscillator kept on in every state here

   // ----------------------------------------
   // APB read side
   // ----------------------------------------
   always_comb
   begin
      rdata = 32'h0000_0000;
      pslverr_o = 1'b0;
      unique case (paddr_i)
         clock_wake_lvd_pkg::ADDR_CLOCK_SOURCE: rdata = {30'h0, clock_source_reg};
         clock_wake_lvd_pkg::ADDR_GAIN: rdata = {29'h0, gain_reg};
         clock_wake_lvd_pkg::ADDR_TRIM: rdata = {26'h0, trim_reg};
         clock_wake_lvd_pkg::ADDR_LOW_VOLTAGE: rdata = {30'h0, lv_reg};
         clock_wake_lvd_pkg::ADDR_WAKE: rdata = {24'h0, wake_reg};
         clock_wake_lvd_pkg::ADDR_CPU_DIV: rdata = {26'h0, cpu_div_reg};
         clock_wake_lvd_pkg::ADDR_STATUS: rdata = {29'h0, gain_code_bad_o, state_reg};
         default: pslverr_o = apb_access; // Unmapped
      endcase
   end

   // Read data registered at the setup cycle
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         prdata_o <= 32'h0000_0000;
      else if (psel_i & ~penable_i & ~pwrite_i)
         prdata_o <= rdata;
   end

   assign pready_o = 1'b1; // Zero wait states
endmodule

//--- inc/clock_wake_lvd_pkg.sv
// Package for the clock, wake-up and low-voltage configuration block.
// Assumes a single 25 MHz clock and an APB register bus with 32-bit data.
package clock_wake_lvd_pkg;
   // ----------------------------------------
   // Register byte addresses (index times four)
   // ----------------------------------------
   localparam int unsigned IDX_CLOCK_SOURCE = 'h00;
   localparam int unsigned IDX_GAIN = 'h01;
   localparam int unsigned IDX_TRIM = 'h02;
   localparam int unsigned IDX_LOW_VOLTAGE = 'h03;
   localparam int unsigned IDX_WAKE = 'h07;
   localparam int unsigned IDX_CPU_DIV = 'h2e;
   localparam int unsigned IDX_STATUS = 'h30;
   localparam logic [7:0] ADDR_CLOCK_SOURCE = 8'(IDX_CLOCK_SOURCE * 4);
   localparam logic [7:0] ADDR_GAIN = 8'(IDX_GAIN * 4);
   localparam logic [7:0] ADDR_TRIM = 8'(IDX_TRIM * 4);
   localparam logic [7:0] ADDR_LOW_VOLTAGE = 8'(IDX_LOW_VOLTAGE * 4);
   localparam logic [7:0] ADDR_WAKE = 8'(IDX_WAKE * 4);
   localparam logic [7:0] ADDR_CPU_DIV = 8'(IDX_CPU_DIV * 4);
   localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
   // ----------------------------------------
   // Reset values and field widths
   // ----------------------------------------
   localparam logic [1:0] CLOCK_SOURCE_RESET = 2'h0;
   localparam logic [2:0] GAIN_RESET = 3'h0;
   localparam logic [5:0] TRIM_RESET = 6'h14;
   localparam logic [5:0] TRIM_MAX = 6'h28;
   localparam logic [1:0] LOW_VOLTAGE_RESET = 2'h2;
   localparam logic [7:0] WAKE_RESET = 8'h00;
   localparam logic [5:0] CPU_DIV_RESET = 6'h00;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned INITIAL_DELAY_CYCLES = 4096;
   localparam int unsigned PRESCALE_UNIT_CYCLES = 4096;
   localparam int unsigned CLK_PERIOD_NS = 40;
   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      SRC_INTERNAL = 2'b00,
      SRC_EXTERNAL = 2'b01,
      SRC_RC = 2'b10
   } clock_source_t;
   typedef enum logic [1:0]
   {
      LV_OFF = 2'b00,
      LV_MEDIUM = 2'b01,
      LV_LOWEST = 2'b10,
      LV_HIGHEST = 2'b11
   } lv_level_t;
endpackage

//--- testbench/clock_wake_lvd_config_sva.sv
// Checker for the clock, wake-up and low-voltage block.
// Assumes binding to the design top; one clock domain.
module clock_wake_lvd_config_sva #(
   parameter int unsigned INIT_CYCLES = 4096,
   parameter int unsigned UNIT_CYCLES = 4096
) (
   // Clock, reset and fast cause
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic lvd_reset_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [7:0] paddr_i,
   input wire logic pslverr_o,
   // Clock network controls
   input wire logic cpu_clk_en_o,
   input wire logic periph_clk_en_o,
   input wire logic [1:0] clock_source_o,
   input wire logic [7:0] gain_stage_en_o,
   input wire logic gain_code_bad_o,
   input wire logic [5:0] trim_o,
   input wire logic [1:0] lv_level_o,
   input wire logic lv_enable_o,
   input wire logic cpu_run_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------
   // Properties
   // ------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   a_periph_run: assert property (periph_clk_en_o == cpu_run_o)
      else $error("peripheral enable differs from run");
   a_cpu_gated: assert property (!cpu_run_o |-> !cpu_clk_en_o)
      else $error("cpu enable while halted");
   a_source_legal: assert property (clock_source_o != 2'b11)
      else $error("illegal clock source code");
   a_gain_bad_off: assert property (gain_code_bad_o |-> gain_stage_en_o == 8'h00)
      else $error("stages on for a bad gain code");
   a_gain_thermo: assert property (gain_stage_en_o inside {8'h00, 8'h01, 8'h07, 8'h3F, 8'hFF})
      else $error("gain stage pattern illegal");
   a_lv_enable_map: assert property (lv_enable_o == (lv_level_o != 2'b00))
      else $error("detector enable mismatch");
   a_opts_frozen: assert property (!$past(reset_i) |-> $stable(trim_o) && $stable(lv_level_o)
      && $stable(clock_source_o) && $stable(gain_stage_en_o))
      else $error("option output changed while running");
   a_fast_restart: assert property ($rose(lvd_reset_i) |-> ##[1:5] cpu_run_o)
      else $error("fast restart too slow");
   a_init_hold: assert property ($fell(reset_i) |-> !cpu_run_o [*8])
      else $error("cpu ran during initial delay");
   a_div_no_err: assert property (psel_i && penable_i
      && paddr_i == clock_wake_lvd_pkg::ADDR_CPU_DIV |-> !pslverr_o)
      else $error("error on divider access");
endmodule

bind clock_wake_lvd_config clock_wake_lvd_config_sva #(.INIT_CYCLES(INIT_CYCLES),
   .UNIT_CYCLES(UNIT_CYCLES)) chk_u (.clk_i, .reset_i, .lvd_reset_i, .psel_i, .penable_i,
   .paddr_i, .pslverr_o, .cpu_clk_en_o, .periph_clk_en_o, .clock_source_o, .gain_stage_en_o,
   .gain_code_bad_o, .trim_o, .lv_level_o, .lv_enable_o, .cpu_run_o);

//--- testbench/clock_source_model.sv
// Option byte source of the clock source network.
// Assumes the bench sets requested bytes: src, gain, trim, level, wake.
module clock_source_model (
   // Control
   input wire logic reset_i,
   input wire logic scramble_i,
   input wire logic [39:0] req_i,
   // Option bytes
   output logic [39:0] opt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Trim clamped; bytes inverted after reset when scrambled
   always_comb
   begin
      opt_o = req_i;
      if (req_i[23:16] > 8'h28)
      begin
         opt_o[23:16] = 8'h28;
      end
      if (scramble_i && !reset_i)
      begin
         opt_o = ~opt_o;
      end
   end
endmodule

//--- testbench/test_clock_wake_lvd_config.sv
// Self-checking bench of the clock, wake-up and low-voltage block.
// Assumes small sequencer counts and the option byte model.
module test_clock_wake_lvd_config;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int INIT = 8;
   localparam int UNIT = 4;
   // Bench signals
   logic clk_i = 0, reset_i = 1, halt_wake_i = 0, lvd_reset_i = 0, scramble = 0;
   logic ext_reset_i = 0, por_reset_i = 0, wdog_reset_i = 0;
   logic psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
   logic [7:0] paddr_i = 0, gain_stage_en_o;
   logic [31:0] pwdata_i = 0, prdata_o, rd;
   logic [39:0] req = 40'h0000_1402_00, opt;
   logic cpu_clk_en_o, periph_clk_en_o, gain_code_bad_o, lv_enable_o, cpu_run_o, er, osc_en;
   logic [1:0] clock_source_o, lv_level_o;
   logic [5:0] trim_o;
   logic [19:0] outs;
   int bad_count = 0, check_count = 0, n;
   // Rows: src, gain, trim, level, wake, expected stages
   logic [47:0] rows[8] = '{48'h0000_1402_0000, 48'h0105_2801_023F, 48'h0302_0000_0000,
      48'h0201_0103_0101, 48'h0103_2702_0007, 48'h0204_1001_0300, 48'h0107_0503_00FF,
      48'h0006_1400_0500};
   // Divider rows: select, period
   logic [15:0] divs[8] = '{16'h0001, 16'h0102, 16'h0204, 16'h0408, 16'h0810,
      16'h1020, 16'h2040, 16'h0340};
   logic [7:0] ra[6] = '{clock_wake_lvd_pkg::ADDR_CLOCK_SOURCE, clock_wake_lvd_pkg::ADDR_GAIN,
      clock_wake_lvd_pkg::ADDR_TRIM, clock_wake_lvd_pkg::ADDR_LOW_VOLTAGE,
      clock_wake_lvd_pkg::ADDR_WAKE, clock_wake_lvd_pkg::ADDR_CPU_DIV};
   logic [7:0] re[6] = '{8'h00, 8'h00, 8'h14, 8'h02, 8'h00, 8'h00};
   assign outs = {clock_source_o, gain_stage_en_o, gain_code_bad_o, trim_o, lv_level_o,
      lv_enable_o};
   // Clock
   always #20 clk_i = ~clk_i;
   clock_source_model src_u (.reset_i(reset_i), .scramble_i(scramble), .req_i(req),
      .opt_o(opt));
   clock_wake_lvd_config #(.INIT_CYCLES(INIT), .UNIT_CYCLES(UNIT)) dut_u (.clk_i(clk_i),
      .reset_i(reset_i), .ext_reset_i(ext_reset_i), .por_reset_i(por_reset_i),
      .halt_wake_i(halt_wake_i),
      .lvd_reset_i(lvd_reset_i), .wdog_reset_i(wdog_reset_i), .opt_clock_source_i(opt[39:32]),
      .opt_gain_i(opt[31:24]), .opt_trim_i(opt[23:16]), .opt_low_voltage_i(opt[15:8]),
      .opt_wake_i(opt[7:0]), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
      .clock_source_o(clock_source_o), .gain_stage_en_o(gain_stage_en_o),
      .gain_code_bad_o(gain_code_bad_o), .trim_o(trim_o), .lv_level_o(lv_level_o),
      .lv_enable_o(lv_enable_o), .osc_enable_o(osc_en), .cpu_run_o(cpu_run_o));
   // ------------------
   // Tasks
   // ------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask
   task automatic expire(input logic hit);
      if (hit)
      begin
         chk("wait", 32'h0000_0000, 32'h0000_0001);
         summarize();
      end
   endtask
   // One APB transfer; held until pready sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (pready_o !== 1'b1 && k < 20);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      expire(k >= 20);
   endtask
   // Reset held six cycles with new option bytes
   task automatic restart(input logic [39:0] q);
      @(posedge clk_i);
      req <= q;
      reset_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
   endtask
   // Cycles until the CPU runs
   task automatic run_wait();
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (cpu_run_o !== 1'b1 && n < 400);
      expire(n >= 400);
   endtask
   // Cycles between CPU clock enables, after one settling pulse
   task automatic period();
      repeat (2)
      begin
         n = 0;
         do
         begin
            @(negedge clk_i);
            n++;
         end
         while (cpu_clk_en_o !== 1'b1 && n < 200);
      end
      expire(n >= 200);
   endtask
   // Slow cause pulse (ext, por, halt), then wait for the CPU to stop
   task automatic halt_stop(input logic [2:0] c);
      @(posedge clk_i);
      {ext_reset_i, por_reset_i, halt_wake_i} <= c;
      @(posedge clk_i);
      {ext_reset_i, por_reset_i, halt_wake_i} <= 3'h0;
      n = 0;
      while (cpu_run_o === 1'b1 && n < 10)
      begin
         @(negedge clk_i);
         n++;
      end
      expire(n >= 10);
   endtask
   // Expected count: reset state, delays, then the first running sample
   function automatic logic [31:0] dly(input logic [47:0] r);
      return 32'(2 + INIT + ((r[47:40] == 8'h00) ? 0 : (int'(r[15:8]) + 1) * UNIT));
   endfunction
   function automatic logic [31:0] expo(input logic [47:0] r);
      return {12'h000, (r[41] ? 2'b10 : r[41:40]), r[7:0], (r[34:32] != 3'h0 && !r[32]),
         r[29:24], r[17:16], (r[17:16] != 2'h0)};
   endfunction
   // ------------------
   // Sequence
   // ------------------
   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         restart(rows[i][47:8]);
         run_wait();
         chk("start delay", dly(rows[i]), 32'(n));
         chk("controls", expo(rows[i]), {12'h000, outs});
         for (int k = 0; k < 6 && i == 0; k++)
         begin
            apb(1'b0, ra[k], 32'h0000_0000);
            chk("reset value", {24'h00_0000, re[k]}, rd);
            apb(1'b1, ra[k], 32'hFFFF_FFFF);
            apb(1'b0, ra[k], 32'h0000_0000);
            chk("after write", (k == 5) ? 32'h0000_003F : {24'h00_0000, re[k]}, rd);
         end
      end
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0000_0000, er});
      apb(1'b0, clock_wake_lvd_pkg::ADDR_STATUS, 32'h0000_0000);
      chk("status", 32'h0000_0007, rd);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, clock_wake_lvd_pkg::ADDR_CPU_DIV, {24'h00_0000, divs[i][15:8]});
         period();
         chk("divide period", {24'h00_0000, divs[i][7:0]}, 32'(n));
      end
      scramble <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("frozen controls", expo(rows[7]), {12'h000, outs});
      scramble <= 1'b0;
      // Halt wake, power-on and external causes each restart at the initial delay
      for (int c = 0; c < 3; c++)
      begin
         halt_stop(3'(1 << c));
         run_wait();
         chk("slow restart", 32'(INIT), 32'(n));
      end
      // Watchdog then detector cause: immediate restart
      for (int c = 0; c < 2; c++)
      begin
         halt_stop(3'b001);
         @(posedge clk_i);
         {lvd_reset_i, wdog_reset_i} <= 2'(1 << c);
         @(posedge clk_i);
         {lvd_reset_i, wdog_reset_i} <= 2'b00;
         run_wait();
         chk("fast restart", 32'h0000_0001, 32'(n <= 5));
         chk("oscillator on", 32'h0000_0001, {31'h0000_0000, osc_en});
      end
      summarize();
   end
endmodule
